//--- idr_defs.svh
// constants for the interrupt distributor register block
// assumes a 12-bit byte address on the register port, 32-bit data
`ifndef IDR_DEFS_SVH
`define IDR_DEFS_SVH

`define IDR_ADDR_W 12
`define IDR_OFF_PEND0 12'h014
`define IDR_OFF_PEND1 12'h034
`define IDR_OFF_PEND2 12'h074
`define IDR_OFF_DEB0 12'h058
`define IDR_OFF_DEB1 12'h05C
`define IDR_OFF_DEB2 12'h078
`define IDR_OFF_ACT0 12'h600
`define IDR_OFF_ACT1 12'h604
`define IDR_OFF_ACT2 12'h608
`define IDR_OFF_PRIO 12'h200
`define IDR_OFF_TGT 12'h400
`define IDR_TGT_GRP_STRIDE 12'h020
`define IDR_OFF_SGI_PRIO 12'h660
`define IDR_OFF_SGI_LAST 12'h66C
`define IDR_OFF_SGI_CTRL 12'h680
`define IDR_OFF_MATCH 12'h6A0
`define IDR_WORD_BYTES 12'h004

`define IDR_PRIO_W 4
`define IDR_LANE_W 8
`define IDR_LANES 4
`define IDR_GRP_BITS 32
`define IDR_PRIO_RST 4'h0
`define IDR_PRIO_LOWEST 4'hF
`define IDR_TRIG_ID_LSB 0
`define IDR_TRIG_ID_W 9
`define IDR_TRIG_DEST_LSB 9
`define IDR_TRIG_DEST_W 8
`define IDR_SPI_ID_BASE 32
`define IDR_RESP_OKAY 2'h0
`define IDR_RESP_SLVERR 2'h2

`endif

//--- idr_pkg.sv
// types shared by the distributor register block
// assumes nothing beyond the constants header
package idr_pkg;
  typedef enum logic [2:0] {
    IDR_ST_IDLE = 3'b000,
    IDR_ST_AR = 3'b001,
    IDR_ST_R = 3'b010,
    IDR_ST_AW = 3'b011,
    IDR_ST_W = 3'b100,
    IDR_ST_B = 3'b101
  } idr_state_type;
endpackage

//--- idr_deglitch.sv
// input synchroniser plus optional one-cycle deglitch per line
// assumes lines arrive asynchronously to clk_sys
`timescale 1ns/10ps
module idr_deglitch #(
  parameter int WIDTH = 93
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [WIDTH-1:0] line_in,
  input wire logic [WIDTH-1:0] filt_en,
  output logic [WIDTH-1:0] line_out
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_line
      logic meta_r;
      logic sync_r;
      logic prev_r;
      logic out_r;
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          prev_r <= 1'b0;
          out_r <= 1'b0;
        end else begin
          meta_r <= line_in[g];
          sync_r <= meta_r;
          prev_r <= sync_r;
          // with filt_en set, a level must hold two samples before it passes
          if (!filt_en[g] || (sync_r == prev_r)) begin
            out_r <= sync_r;
          end
        end
      end
      assign line_out[g] = out_r;
    end
  endgenerate
endmodule // idr_deglitch

//--- idr_regs.sv
// distributor registers: pending, deglitch, in-service, priorities,
// routing, banked soft priorities, soft trigger, cpu id match
// assumes an AXI master issuing single-beat 32-bit accesses
`timescale 1ns/10ps
`include "idr_defs.svh"
module idr_regs #(
  parameter int SPI_NUM = 93,
  parameter int CPU_NUM = 7,
  parameter int SGI_NUM = 16,
  parameter int ID_W = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [SPI_NUM-1:0] irq_in,
  input wire logic [SPI_NUM-1:0] spi_enable,
  input wire logic [CPU_NUM*SPI_NUM-1:0] spi_active_cpu,
  input wire logic [ID_W-1:0] awid,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [ID_W-1:0] bid,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ID_W-1:0] arid,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [ID_W-1:0] rid,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rlast,
  output logic rvalid,
  input wire logic rready,
  output logic [SPI_NUM-1:0] spi_pending_r,
  output logic [SPI_NUM-1:0] spi_soft_raise_r,
  output logic [CPU_NUM*SGI_NUM-1:0] sgi_raise_r,
  output logic [CPU_NUM*SPI_NUM-1:0] cpu_route_r,
  output logic [CPU_NUM-1:0] best_valid_r,
  output logic [CPU_NUM*9-1:0] best_id_r,
  output logic [CPU_NUM*4-1:0] best_prio_r
);
  localparam int EXT = 3 * `IDR_GRP_BITS;
  localparam int PRIO_WORDS = (SPI_NUM + 3) / 4;
  localparam int SGI_WORDS = (SGI_NUM + 3) / 4;

  idr_pkg::idr_state_type state_r;
  logic last_rd_r;
  logic [11:0] addr_r;
  logic [ID_W-1:0] id_r;
  logic [SPI_NUM-1:0] raw_line;
  logic [SPI_NUM-1:0] deglitch_r;
  logic [SPI_NUM-1:0] in_service;
  logic [3:0] prio_r [SPI_NUM];
  logic [SPI_NUM-1:0] tgt_r [CPU_NUM];
  logic [3:0] sgi_prio_r [CPU_NUM][SGI_NUM];
  logic [ID_W-1:0] match_r [CPU_NUM];
  logic [11:0] sel_addr;
  logic [ID_W-1:0] sel_id;
  logic bank_hit;
  logic [2:0] bank_cpu;
  logic [31:0] rd_nxt;
  logic rd_err;
  logic wr_fire;
  logic [31:0] wmask;
  logic [EXT-1:0] pend_ext;
  logic [EXT-1:0] deb_ext;
  logic [EXT-1:0] act_ext;
  logic arb_v [CPU_NUM];
  logic [3:0] arb_p [CPU_NUM];
  logic [8:0] arb_i [CPU_NUM];

  idr_deglitch #(.WIDTH(SPI_NUM)) u_deglitch (
    .clk_sys(clk_sys),
    .srst(srst),
    .line_in(irq_in),
    .filt_en(deglitch_r),
    .line_out(raw_line)
  );

  // bus sequencing: one command at a time, no command queue
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= idr_pkg::IDR_ST_IDLE;
      last_rd_r <= 1'b0;
      addr_r <= 12'h000;
      id_r <= '0;
    end else begin
      case (state_r)
        idr_pkg::IDR_ST_IDLE: begin
          // a read beats a write only right after another read
          if (arvalid && (!awvalid || last_rd_r)) begin
            state_r <= idr_pkg::IDR_ST_AR;
          end else if (awvalid) begin
            state_r <= idr_pkg::IDR_ST_AW;
          end
        end
        idr_pkg::IDR_ST_AR: begin
          addr_r <= araddr;
          id_r <= arid;
          last_rd_r <= 1'b1;
          state_r <= idr_pkg::IDR_ST_R;
        end
        idr_pkg::IDR_ST_R: begin
          if (rready) begin
            state_r <= idr_pkg::IDR_ST_IDLE;
          end
        end
        idr_pkg::IDR_ST_AW: begin
          addr_r <= awaddr;
          id_r <= awid;
          last_rd_r <= 1'b0;
          state_r <= idr_pkg::IDR_ST_W;
        end
        idr_pkg::IDR_ST_W: begin
          if (wvalid) begin
            state_r <= idr_pkg::IDR_ST_B;
          end
        end
        idr_pkg::IDR_ST_B: begin
          if (bready) begin
            state_r <= idr_pkg::IDR_ST_IDLE;
          end
        end
        default: state_r <= idr_pkg::IDR_ST_IDLE;
      endcase
    end
  end

  // handshake outputs, all registered
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      arready <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      rvalid <= 1'b0;
      bvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `IDR_RESP_OKAY;
      bresp <= `IDR_RESP_OKAY;
      rid <= '0;
      bid <= '0;
      rlast <= 1'b0;
    end else begin
      arready <= (state_r == idr_pkg::IDR_ST_IDLE) && arvalid &&
                 (!awvalid || last_rd_r);
      awready <= (state_r == idr_pkg::IDR_ST_IDLE) && awvalid &&
                 !(arvalid && (!awvalid || last_rd_r));
      wready <= (state_r == idr_pkg::IDR_ST_AW) ||
                ((state_r == idr_pkg::IDR_ST_W) && !wvalid);
      if (state_r == idr_pkg::IDR_ST_AR) begin
        rvalid <= 1'b1;
        rlast <= 1'b1;
        rdata <= rd_nxt;
        rresp <= rd_err ? `IDR_RESP_SLVERR : `IDR_RESP_OKAY;
        rid <= arid;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        rlast <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= rd_err ? `IDR_RESP_SLVERR : `IDR_RESP_OKAY;
        bid <= id_r;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  assign wr_fire = (state_r == idr_pkg::IDR_ST_W) && wvalid && wready;
  assign sel_addr = (state_r == idr_pkg::IDR_ST_AR) ? araddr : addr_r;
  assign sel_id = (state_r == idr_pkg::IDR_ST_AR) ? arid : id_r;
  assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}},
                  {8{wstrb[0]}}};

  // bank choice: lowest cpu whose tag equals the access id
  always_comb begin
    bank_hit = 1'b0;
    bank_cpu = 3'h0;
    for (int c = CPU_NUM - 1; c >= 0; c--) begin
      if (match_r[c] == sel_id) begin
        bank_hit = 1'b1;
        bank_cpu = 3'(c);
      end
    end
  end

  always_comb begin
    pend_ext = '0;
    deb_ext = '0;
    act_ext = '0;
    in_service = '0;
    pend_ext[SPI_NUM-1:0] = spi_pending_r;
    deb_ext[SPI_NUM-1:0] = deglitch_r;
    for (int i = 0; i < SPI_NUM; i++) begin
      for (int c = 0; c < CPU_NUM; c++) begin
        in_service[i] = in_service[i] |
                        spi_active_cpu[c*SPI_NUM+i];
      end
    end
    act_ext[SPI_NUM-1:0] = in_service;
  end

  // read decode; unmapped addresses answer slverr with zero data
  always_comb begin
    int w;
    int idx;
    int c;
    w = 0;
    idx = 0;
    c = 0;
    rd_nxt = 32'h0000_0000;
    rd_err = 1'b0;
    case (sel_addr)
      `IDR_OFF_PEND0: rd_nxt = pend_ext[31:0];
      `IDR_OFF_PEND1: rd_nxt = pend_ext[63:32];
      `IDR_OFF_PEND2: rd_nxt = pend_ext[95:64];
      `IDR_OFF_DEB0: rd_nxt = deb_ext[31:0];
      `IDR_OFF_DEB1: rd_nxt = deb_ext[63:32];
      `IDR_OFF_DEB2: rd_nxt = deb_ext[95:64];
      `IDR_OFF_ACT0: rd_nxt = act_ext[31:0];
      `IDR_OFF_ACT1: rd_nxt = act_ext[63:32];
      `IDR_OFF_ACT2: rd_nxt = act_ext[95:64];
      `IDR_OFF_SGI_CTRL: rd_nxt = 32'h0000_0000;
      default: begin
        rd_err = 1'b1;
        if (sel_addr >= `IDR_OFF_PRIO &&
            sel_addr < `IDR_OFF_PRIO + 12'(PRIO_WORDS * 4)) begin
          rd_err = 1'b0;
          w = int'((sel_addr - `IDR_OFF_PRIO) >> 2);
          for (int b = 0; b < `IDR_LANES; b++) begin
            idx = w * `IDR_LANES + b;
            if (idx < SPI_NUM) begin
              rd_nxt[b*`IDR_LANE_W +: `IDR_PRIO_W] = prio_r[idx];
            end
          end
        end else if (sel_addr >= `IDR_OFF_TGT &&
                     sel_addr < `IDR_OFF_TGT + 3 * `IDR_TGT_GRP_STRIDE &&
                     sel_addr[4:2] < 3'(CPU_NUM) && sel_addr[1:0] == 2'h0)
        begin
          rd_err = 1'b0;
          w = int'((sel_addr - `IDR_OFF_TGT) >> 5);
          c = int'(sel_addr[4:2]);
          for (int b = 0; b < `IDR_GRP_BITS; b++) begin
            idx = w * `IDR_GRP_BITS + b;
            if (idx < SPI_NUM) begin
              rd_nxt[b] = tgt_r[c][idx];
            end
          end
        end else if (sel_addr >= `IDR_OFF_SGI_PRIO &&
                     sel_addr <= `IDR_OFF_SGI_LAST) begin
          rd_err = 1'b0;
          w = int'((sel_addr - `IDR_OFF_SGI_PRIO) >> 2);
          for (int b = 0; b < `IDR_LANES; b++) begin
            idx = w * `IDR_LANES + b;
            if (bank_hit && idx < SGI_NUM) begin
              rd_nxt[b*`IDR_LANE_W +: `IDR_PRIO_W] =
                sgi_prio_r[bank_cpu][idx];
            end
          end
        end else if (sel_addr >= `IDR_OFF_MATCH &&
                     sel_addr < `IDR_OFF_MATCH + 12'(CPU_NUM * 4)) begin
          rd_err = 1'b0;
          c = int'((sel_addr - `IDR_OFF_MATCH) >> 2);
          rd_nxt[ID_W-1:0] = match_r[c];
        end
      end
    endcase
  end

  // deglitch control words
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      deglitch_r <= '0;
    end else if (wr_fire) begin
      for (int i = 0; i < SPI_NUM; i++) begin
        if ((addr_r == `IDR_OFF_DEB0 && i / 32 == 0) ||
            (addr_r == `IDR_OFF_DEB1 && i / 32 == 1) ||
            (addr_r == `IDR_OFF_DEB2 && i / 32 == 2)) begin
          if (wmask[i%32]) begin
            deglitch_r[i] <= wdata[i%32];
          end
        end
      end
    end
  end

  // shared priorities, four per word, nibble per lane
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < SPI_NUM; i++) begin
        prio_r[i] <= `IDR_PRIO_RST;
      end
    end else if (wr_fire && addr_r >= `IDR_OFF_PRIO &&
                 addr_r < `IDR_OFF_PRIO + 12'(PRIO_WORDS * 4)) begin
      for (int i = 0; i < SPI_NUM; i++) begin
        if (i / 4 == int'((addr_r - `IDR_OFF_PRIO) >> 2) &&
            wstrb[i%4]) begin
          prio_r[i] <= wdata[(i%4)*`IDR_LANE_W +: `IDR_PRIO_W];
        end
      end
    end
  end

  // routing words, written directly or by a shared soft trigger
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int c = 0; c < CPU_NUM; c++) begin
        tgt_r[c] <= '0;
      end
    end else if (wr_fire && addr_r == `IDR_OFF_SGI_CTRL) begin
      for (int c = 0; c < CPU_NUM; c++) begin
        for (int i = 0; i < SPI_NUM; i++) begin
          if (int'(wdata[`IDR_TRIG_ID_LSB +: `IDR_TRIG_ID_W]) ==
              i + `IDR_SPI_ID_BASE) begin
            tgt_r[c][i] <= wdata[`IDR_TRIG_DEST_LSB + c];
          end
        end
      end
    end else if (wr_fire && addr_r >= `IDR_OFF_TGT &&
                 addr_r < `IDR_OFF_TGT + 3 * `IDR_TGT_GRP_STRIDE) begin
      for (int c = 0; c < CPU_NUM; c++) begin
        for (int i = 0; i < SPI_NUM; i++) begin
          if (int'(addr_r[4:2]) == c && addr_r[1:0] == 2'h0 &&
              i / 32 == int'((addr_r - `IDR_OFF_TGT) >> 5) &&
              wmask[i%32]) begin
            tgt_r[c][i] <= wdata[i%32];
          end
        end
      end
    end
  end

  // banked soft priorities and cpu id tags
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int c = 0; c < CPU_NUM; c++) begin
        match_r[c] <= ID_W'(c);
        for (int s = 0; s < SGI_NUM; s++) begin
          sgi_prio_r[c][s] <= `IDR_PRIO_RST;
        end
      end
    end else if (wr_fire) begin
      for (int c = 0; c < CPU_NUM; c++) begin
        if (addr_r == `IDR_OFF_MATCH + 12'(c * 4)) begin
          for (int b = 0; b < ID_W; b++) begin
            if (wmask[b]) begin
              match_r[c][b] <= wdata[b];
            end
          end
        end
        for (int s = 0; s < SGI_NUM; s++) begin
          if (bank_hit && int'(bank_cpu) == c && wstrb[s%4] &&
              addr_r == `IDR_OFF_SGI_PRIO + 12'((s / 4) * 4)) begin
            sgi_prio_r[c][s] <=
              wdata[(s%4)*`IDR_LANE_W +: `IDR_PRIO_W];
          end
        end
      end
    end
  end

  // soft trigger pulses; ids 16..31 and past the last shared are dropped
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sgi_raise_r <= '0;
      spi_soft_raise_r <= '0;
    end else begin
      sgi_raise_r <= '0;
      spi_soft_raise_r <= '0;
      if (wr_fire && addr_r == `IDR_OFF_SGI_CTRL) begin
        for (int c = 0; c < CPU_NUM; c++) begin
          for (int s = 0; s < SGI_NUM; s++) begin
            if (int'(wdata[`IDR_TRIG_ID_LSB +: `IDR_TRIG_ID_W]) == s) begin
              sgi_raise_r[c*SGI_NUM+s] <=
                wdata[`IDR_TRIG_DEST_LSB + c];
            end
          end
        end
        for (int i = 0; i < SPI_NUM; i++) begin
          if (int'(wdata[`IDR_TRIG_ID_LSB +: `IDR_TRIG_ID_W]) ==
              i + `IDR_SPI_ID_BASE) begin
            spi_soft_raise_r[i] <=
              |wdata[`IDR_TRIG_DEST_LSB +: `IDR_TRIG_DEST_W];
          end
        end
      end
    end
  end

  // best routed pending shared interrupt per cpu
  always_comb begin
    for (int c = 0; c < CPU_NUM; c++) begin
      arb_v[c] = 1'b0;
      arb_p[c] = `IDR_PRIO_LOWEST;
      arb_i[c] = 9'h000;
      for (int i = 0; i < SPI_NUM; i++) begin
        // strict compare keeps the lower id on a tie
        if (spi_pending_r[i] && tgt_r[c][i] &&
            (!arb_v[c] || prio_r[i] < arb_p[c])) begin
          arb_v[c] = 1'b1;
          arb_p[c] = prio_r[i];
          arb_i[c] = 9'(i + `IDR_SPI_ID_BASE);
        end
      end
    end
  end

  // pending and routing; soft triggers never set pending bits, they reach routing only via tgt_r
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      spi_pending_r <= '0;
      cpu_route_r <= '0;
      best_valid_r <= '0;
      best_id_r <= '0;
      best_prio_r <= '0;
    end else begin
      spi_pending_r <= raw_line & spi_enable;
      for (int c = 0; c < CPU_NUM; c++) begin
        cpu_route_r[c*SPI_NUM +: SPI_NUM] <=
          spi_pending_r & tgt_r[c];
        best_valid_r[c] <= arb_v[c];
        best_id_r[c*9 +: 9] <= arb_i[c];
        best_prio_r[c*4 +: 4] <= arb_p[c];
      end
    end
  end
endmodule // idr_regs

//--- idr_regs_assertions.sv
// port checker for the distributor register block
// assumes it is bound onto idr_regs, one clock, sync reset
`timescale 1ns/10ps
module idr_regs_assertions #(
  parameter int SPI_NUM = 93,
  parameter int CPU_NUM = 7,
  parameter int SGI_NUM = 16
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [SPI_NUM-1:0] spi_enable,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [SPI_NUM-1:0] spi_pending_r,
  input wire logic [SPI_NUM-1:0] spi_soft_raise_r,
  input wire logic [CPU_NUM*SGI_NUM-1:0] sgi_raise_r,
  input wire logic [CPU_NUM*SPI_NUM-1:0] cpu_route_r
);
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  pend_masked_a: assert property (
    (spi_pending_r & ~$past(spi_enable)) == '0)
    else $error("pending bit set while its enable was low");
  route_subset_a: assert property (
    (cpu_route_r & ~{CPU_NUM{$past(spi_pending_r)}}) == '0)
    else $error("routed bit without a pending interrupt");
  soft_cause_a: assert property (
    sgi_raise_r != '0 |-> $past(wvalid && wready))
    else $error("soft interrupt raised without a write");
  soft_once_a: assert property (
    sgi_raise_r != '0 |=> sgi_raise_r == '0)
    else $error("soft interrupt raise longer than one cycle");
  shared_trig_a: assert property (
    spi_soft_raise_r != '0 |-> $past(wvalid && wready))
    else $error("shared trigger raised without a write");
  read_answer_a: assert property (
    arready |=> rvalid && !arready)
    else $error("read data not presented after address accept");
  read_hold_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped or changed before accept");
  write_resp_a: assert property (
    wvalid && wready |=> (bvalid and
      (!bready |=> bvalid && $stable(bresp))))
    else $error("write response missing or unstable");
endmodule // idr_regs_assertions

bind idr_regs idr_regs_assertions #(.SPI_NUM(SPI_NUM), .CPU_NUM(CPU_NUM),
  .SGI_NUM(SGI_NUM)) idr_regs_assertions_i (.clk_sys(clk_sys),
  .srst(srst), .spi_enable(spi_enable), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .spi_pending_r(spi_pending_r), .spi_soft_raise_r(spi_soft_raise_r),
  .sgi_raise_r(sgi_raise_r), .cpu_route_r(cpu_route_r));

//--- idr_cpu_model.sv
// processor-side AXI master model, single-beat 32-bit accesses
// assumes tasks are entered just after a rising edge, one at a time
`timescale 1ns/10ps
module idr_cpu_model (
  input wire logic clk_sys,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  output logic [3:0] awid,
  output logic [11:0] awaddr,
  output logic awvalid,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  output logic bready,
  output logic [3:0] arid,
  output logic [11:0] araddr,
  output logic arvalid,
  output logic rready,
  output logic hung
);
  localparam int LIM = 40;
  initial begin
    {awid, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {arid, araddr, arvalid, rready, hung} = '0;
  end
  // released lines carry the inverse, so stale values never match
  task automatic wr(input logic [3:0] id, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    awid <= id;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (n = 0; !n || (awready !== 1'h1 && n < LIM); n++)
      @(posedge clk_sys);
    if (n >= LIM)
      hung <= 1'h1;
    awvalid <= 1'h0;
    awaddr <= ~a;
    awid <= ~id;
    for (n = 0; !n || (wready !== 1'h1 && n < LIM); n++)
      @(posedge clk_sys);
    if (n >= LIM)
      hung <= 1'h1;
    wvalid <= 1'h0;
    wdata <= ~d;
    wstrb <= ~s;
    // a busy core: one stall cycle before taking the answer
    @(posedge clk_sys);
    bready <= 1'h1;
    for (n = 0; !n || (bvalid !== 1'h1 && n < LIM); n++)
      @(posedge clk_sys);
    if (n >= LIM)
      hung <= 1'h1;
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] id, input logic [11:0] a,
    output logic [31:0] d, output logic [1:0] r);
    int n;
    arid <= id;
    araddr <= a;
    arvalid <= 1'h1;
    for (n = 0; !n || (arready !== 1'h1 && n < LIM); n++)
      @(posedge clk_sys);
    if (n >= LIM)
      hung <= 1'h1;
    arvalid <= 1'h0;
    araddr <= ~a;
    arid <= ~id;
    @(posedge clk_sys);
    rready <= 1'h1;
    for (n = 0; !n || (rvalid !== 1'h1 && n < LIM); n++)
      @(posedge clk_sys);
    if (n >= LIM)
      hung <= 1'h1;
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
endmodule // idr_cpu_model

//--- testbench.sv
// self-checking bench for the distributor register block
// assumes default sizes: 93 shared lines, 7 cpus, 4-bit ids
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  logic acc_clr = 1'h1;
  logic [92:0] irq_in = '0, spi_enable = '0;
  logic [650:0] spi_active_cpu = '0, cpu_route_r;
  logic [3:0] awid, arid, bid, rid, wstrb;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic awvalid, awready, wvalid, wready, bvalid, bready, hung;
  logic arvalid, arready, rvalid, rready, rlast, pend0_acc;
  logic [1:0] bresp, rresp, rr;
  logic [92:0] spi_pending_r, spi_soft_raise_r, soft_acc;
  logic [111:0] sgi_raise_r, sgi_acc;
  logic [6:0] best_valid_r;
  logic [62:0] best_id_r;
  logic [27:0] best_prio_r;
  int err_count = 0;
  int checks_done = 0;

  idr_regs idr_regs_i (.clk_sys(clk_sys), .srst(srst), .irq_in(irq_in),
    .spi_enable(spi_enable), .spi_active_cpu(spi_active_cpu),
    .awid(awid), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bid(bid), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .arid(arid), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rid(rid), .rdata(rdata), .rresp(rresp), .rlast(rlast),
    .rvalid(rvalid), .rready(rready), .spi_pending_r(spi_pending_r),
    .spi_soft_raise_r(spi_soft_raise_r), .sgi_raise_r(sgi_raise_r),
    .cpu_route_r(cpu_route_r), .best_valid_r(best_valid_r),
    .best_id_r(best_id_r), .best_prio_r(best_prio_r));
  idr_cpu_model cpu_i (.clk_sys(clk_sys), .awready(awready),
    .wready(wready), .bvalid(bvalid), .bresp(bresp), .arready(arready),
    .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .awid(awid),
    .awaddr(awaddr), .awvalid(awvalid), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .bready(bready), .arid(arid), .araddr(araddr),
    .arvalid(arvalid), .rready(rready), .hung(hung));

  always #25 clk_sys = ~clk_sys;
  // one-cycle pulses are caught here so later checks cannot miss them
  always @(posedge clk_sys) begin
    sgi_acc <= acc_clr ? '0 : sgi_acc | sgi_raise_r;
    soft_acc <= acc_clr ? '0 : soft_acc | spi_soft_raise_r;
    pend0_acc <= acc_clr ? 1'h0 : pend0_acc | spi_pending_r[0];
    if (hung === 1'h1) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] id, input logic [11:0] a,
    input logic [31:0] exp, input logic [1:0] er);
    cpu_i.rd(id, a, rv, rr);
    chk(rv, exp);
    chk(32'(rr), 32'(er));
    chk(32'(rid), 32'(id));
    chk(32'(rlast), 32'h0000_0001);
  endtask
  task automatic wr(input logic [3:0] id, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    cpu_i.wr(id, a, d, s, rr);
    chk(32'(rr), 32'(er));
    chk(32'(bid), 32'(id));
  endtask
  task automatic clr();
    acc_clr <= 1'h1;
    @(posedge clk_sys);
    acc_clr <= 1'h0;
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'h0;
    @(posedge clk_sys);
    for (int c = 0; c < 7; c++)
      rchk(4'h0, 12'h6A0 + 12'(4 * c), 32'(c), 2'h0);
    rchk(4'h0, 12'h6BC, 32'h0000_0000, 2'h2);
    rchk(4'h0, 12'h200, 32'h0000_0000, 2'h0);
    wr(4'h0, 12'h200, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rchk(4'h0, 12'h200, 32'h0F0F_0F0F, 2'h0);
    wr(4'h0, 12'h204, 32'hFFFF_FFFF, 4'h2, 2'h0);
    rchk(4'h0, 12'h204, 32'h0000_0F00, 2'h0);
    wr(4'h1, 12'h660, 32'h0000_0A05, 4'hF, 2'h0);
    wr(4'h2, 12'h660, 32'h0000_0300, 4'hF, 2'h0);
    wr(4'h6, 12'h66C, 32'h0F0F_0F0F, 4'hF, 2'h0);
    rchk(4'h1, 12'h660, 32'h0000_0A05, 2'h0);
    rchk(4'h2, 12'h660, 32'h0000_0300, 2'h0);
    rchk(4'h6, 12'h66C, 32'h0F0F_0F0F, 2'h0);
    rchk(4'h9, 12'h660, 32'h0000_0000, 2'h0);
    rchk(4'h0, 12'h670, 32'h0000_0000, 2'h2);
    wr(4'h0, 12'h7F0, 32'h0000_0001, 4'hF, 2'h2);
    // trigger with no lane strobes and the absent eighth cpu selected
    clr();
    wr(4'h0, 12'h680, 32'h0001_8203, 4'h0, 2'h0);
    chk(32'($countones(sgi_acc)), 32'h0000_0002);
    chk(32'({sgi_acc[99], sgi_acc[3]}), 32'h0000_0003);
    rchk(4'h0, 12'h400, 32'h0000_0000, 2'h0);
    rchk(4'h0, 12'h680, 32'h0000_0000, 2'h0);
    clr();
    wr(4'h0, 12'h680, 32'h0001_FE14, 4'hF, 2'h0);
    wr(4'h0, 12'h680, 32'h0001_FE7D, 4'hF, 2'h0);
    chk(32'($countones({sgi_acc, soft_acc})), 32'h0000_0000);
    wr(4'h0, 12'h680, 32'h0000_087C, 4'hF, 2'h0);
    rchk(4'h0, 12'h448, 32'h1000_0000, 2'h0);
    wr(4'h0, 12'h420, 32'h0000_0003, 4'hF, 2'h0);
    irq_in[33:32] <= 2'h3;
    spi_enable[33:32] <= 2'h3;
    repeat (8) @(posedge clk_sys);
    rchk(4'h0, 12'h034, 32'h0000_0003, 2'h0);
    chk(32'(cpu_route_r[33:32]), 32'h0000_0003);
    chk(32'(cpu_route_r[126:125]), 32'h0000_0000);
    chk(32'({best_valid_r[0], best_prio_r[3:0], best_id_r[8:0]}),
      32'h0000_2040);
    wr(4'h0, 12'h220, 32'h0000_0001, 4'h1, 2'h0);
    chk(32'({best_valid_r[0], best_prio_r[3:0], best_id_r[8:0]}),
      32'h0000_2041);
    clr();
    wr(4'h0, 12'h680, 32'h0000_0441, 4'hF, 2'h0);
    chk(32'(soft_acc[33]), 32'h0000_0001);
    rchk(4'h0, 12'h420, 32'h0000_0001, 2'h0);
    rchk(4'h0, 12'h424, 32'h0000_0002, 2'h0);
    chk(32'(cpu_route_r[126]), 32'h0000_0001);
    spi_enable[32] <= 1'h0;
    spi_active_cpu[3 * 93 + 40] <= 1'h1;
    repeat (8) @(posedge clk_sys);
    rchk(4'h0, 12'h034, 32'h0000_0002, 2'h0);
    rchk(4'h0, 12'h604, 32'h0000_0100, 2'h0);
    rchk(4'h0, 12'h600, 32'h0000_0000, 2'h0);
    spi_enable[0] <= 1'h1;
    // a one-cycle glitch is dropped only while the filter is on
    for (int k = 1; k >= 0; k--) begin
      wr(4'h0, 12'h058, 32'(k), 4'hF, 2'h0);
      rchk(4'h0, 12'h058, 32'(k), 2'h0);
      clr();
      irq_in[0] <= 1'h1;
      @(posedge clk_sys);
      irq_in[0] <= 1'h0;
      repeat (8) @(posedge clk_sys);
      chk(32'(pend0_acc), 32'(1 - k));
    end
    report_and_stop();
  end
endmodule // testbench
